// >>> common/fip_regs.vh
`ifndef FIP_REGS_VH
`define FIP_REGS_VH
// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define FIP_AW 9
`define FIP_DW 32
`define FIP_REG_SMR 2'b00
`define FIP_REG_SVR 2'b01
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FIP_OFS_IVR 9'h100
`define FIP_OFS_FVR 9'h104
`define FIP_OFS_ISR 9'h108
`define FIP_OFS_IPR 9'h10C
`define FIP_OFS_IMR 9'h110
`define FIP_OFS_CISR 9'h114
`define FIP_OFS_IECR 9'h120
`define FIP_OFS_IDCR 9'h124
`define FIP_OFS_ICCR 9'h128
`define FIP_OFS_ISCR 9'h12C
`define FIP_OFS_EOICR 9'h130
`define FIP_OFS_SPU 9'h134
`define FIP_OFS_DCR 9'h138
`define FIP_OFS_FFER 9'h140
`define FIP_OFS_FFDR 9'h144
`define FIP_OFS_FFSR 9'h148
// ----------------------------------------
// Fields
// ----------------------------------------
`define FIP_DCR_PROT 0
`define FIP_DCR_GLOBAL_MASK_BIT 1
`define FIP_CISR_NORM 0
`define FIP_CISR_FAST 1
`define FIP_SMR_PRIO_LSB 0
`define FIP_SMR_SENS_LSB 5
`define FIP_SENS_LOW 2'b00
`define FIP_SENS_NEG 2'b01
`define FIP_SENS_HIGH 2'b10
`define FIP_SENS_POS 2'b11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FIP_RST_WORD 32'h0000_0000
`define FIP_RST_PRIO 3'h0
`define FIP_RST_SENS 2'h0
`define FIP_RST_SRC 5'h00
`define FIP_RST_DEPTH 4'h0
`endif

// >>> rtl/fip_top.v
// What this block does
// - Fast vector read clears edge source 0
// - Force enable/disable commands update force status
// - Forced sources never reach normal arbitration
// - Active forced source asserts fast request
// - Forcing leaves source 0 pending untouched
// - Fast vector read returns source-0 vector
// - With forcing, fast read never clears
// - Normal vector read skips forced sources
// - Source 0 still requests fast normally
// - Protect bit write enables protect mode
// - Normal mode read computes, records, pushes, acks
// - Protect mode defers push/ack to write
// - Protect reads keep context and status
// - Normal mode vector write does nothing
// - Nothing pending returns spurious vector
// - Global mask silences both lines, not wakeup
// - Enable/disable bit 0 controls fast source
// - Source 0 sensitivity used, priority ignored
//
// The address map and the address-and-strobe port were left to the implementer.
`include "fip_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module fip_top #(
    parameter N = 32,
    parameter DEPTH = 8
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire ce_i,
    input wire [N-1:0] src_i,
    input wire [`FIP_AW-1:0] addr_i,
    input wire [`FIP_DW-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [`FIP_DW-1:0] rdata_o,
    output reg normal_request_n_o,
    output reg fast_request_n_o,
    output reg wake_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [N-1:0] prev_ff;
    reg [N-1:0] pend_ff;
    reg [N-1:0] imr_ff;
    reg [N-1:0] ffsr_ff;
    reg [3*N-1:0] prio_ff;
    reg [2*N-1:0] sens_ff;
    reg [`FIP_DW-1:0] spu_ff;
    reg protect_mode_bit_ff;
    reg global_mask_bit_ff;
    reg [3*DEPTH-1:0] lvl_stk_ff;
    reg [5*DEPTH-1:0] src_stk_ff;
    reg [3:0] depth_ff;
    reg [4:0] cur_src_ff;
    reg held_vld_ff;
    reg [4:0] held_src_ff;
    reg [2:0] held_lvl_ff;
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [1:0] region = addr_i[8:7];
    wire [4:0] idx = addr_i[6:2];
    wire in_smr = region == `FIP_REG_SMR;
    wire in_svr = region == `FIP_REG_SVR;
    wire ivr_rd = rd_i && addr_i == `FIP_OFS_IVR;
    wire ivr_wr = wr_i && addr_i == `FIP_OFS_IVR;
    wire fvr_rd = rd_i && addr_i == `FIP_OFS_FVR;
    wire eoi_wr = wr_i && addr_i == `FIP_OFS_EOICR;
    wire force_used = |ffsr_ff;
    function sens_act;
        input [1:0] t;
        input cur;
        input prv;
        begin
            if (!t[0])
                sens_act = cur == t[1];
            else if (t[1])
                sens_act = cur & ~prv;
            else
                sens_act = ~cur & prv;
        end
    endfunction
    // ----------------------------------------
    // Pending view and arbitration
    // ----------------------------------------
    reg [N-1:0] ipr;
    reg [N-1:0] edge_set;
    reg [N-1:0] cand;
    reg found;
    reg [4:0] best_src;
    reg [2:0] best_prio;
    integer i;
    always @*
    begin
        ipr = {N{1'b0}};
        edge_set = {N{1'b0}};
        cand = {N{1'b0}};
        found = 1'b0;
        best_src = `FIP_RST_SRC;
        best_prio = `FIP_RST_PRIO;
        for (i = 0; i < N; i = i + 1)
        begin
            // Detection stays alive for forced sources
            ipr[i] = sens_ff[2*i] ? pend_ff[i] :
                sens_act(sens_ff[2*i +: 2], src_i[i], prev_ff[i]);
            edge_set[i] = sens_ff[2*i] &
                sens_act(sens_ff[2*i +: 2], src_i[i], prev_ff[i]);
        end
        for (i = 1; i < N; i = i + 1)
        begin
            cand[i] = ipr[i] & imr_ff[i] & ~ffsr_ff[i];
            if (cand[i] && (!found || prio_ff[3*i +: 3] > best_prio))
            begin
                found = 1'b1;
                best_src = i[4:0];
                best_prio = prio_ff[3*i +: 3];
            end
        end
    end
    wire [2:0] top = depth_ff[2:0] - 3'h1;
    wire [2:0] cur_lvl = lvl_stk_ff[3*top +: 3];
    // Only a strictly higher level preempts
    wire hit = found && (depth_ff == `FIP_RST_DEPTH || best_prio > cur_lvl);
    wire fast_raw = (ipr[0] & imr_ff[0]) |
        (|(ipr & imr_ff & ffsr_ff));
    // ----------------------------------------
    // Acknowledge and stack control
    // ----------------------------------------
    wire ack_norm = ivr_rd && !protect_mode_bit_ff && hit;
    wire ack_prot = ivr_wr && protect_mode_bit_ff && held_vld_ff;
    wire ack = ack_norm | ack_prot;
    wire [4:0] ack_src = protect_mode_bit_ff ? held_src_ff : best_src;
    wire [2:0] ack_lvl = protect_mode_bit_ff ? held_lvl_ff : best_prio;
    wire do_pop = eoi_wr && depth_ff != `FIP_RST_DEPTH;
    wire do_push = ack && depth_ff != DEPTH;
    wire [2:0] below = depth_ff[2:0] - 3'h2;
    reg [N-1:0] clr;
    always @*
    begin
        clr = {N{1'b0}};
        if (wr_i && addr_i == `FIP_OFS_ICCR)
            clr = wdata_i[N-1:0];
        if (ack && sens_ff[2*ack_src])
            clr[ack_src] = 1'b1;
        // Forcing hands clearing of source 0 to software
        if (fvr_rd && sens_ff[0] && !force_used)
            clr[0] = 1'b1;
    end
    // ----------------------------------------
    // Sources, mask, forcing
    // ----------------------------------------
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prev_ff <= {N{1'b0}};
            pend_ff <= {N{1'b0}};
            imr_ff <= {N{1'b0}};
            ffsr_ff <= {N{1'b0}};
        end
        else if (ce_i)
        begin
            prev_ff <= src_i;
            // New edge beats a same-cycle clear
            pend_ff <= (pend_ff & ~clr) | edge_set;
            if (wr_i && addr_i == `FIP_OFS_IECR)
                imr_ff <= imr_ff | wdata_i[N-1:0];
            else if (wr_i && addr_i == `FIP_OFS_IDCR)
                imr_ff <= imr_ff & ~wdata_i[N-1:0];
            if (wr_i && addr_i == `FIP_OFS_FFER)
                ffsr_ff <= (ffsr_ff | wdata_i[N-1:0]) & ~{{(N-1){1'b0}}, 1'b1};
            else if (wr_i && addr_i == `FIP_OFS_FFDR)
                ffsr_ff <= ffsr_ff & ~wdata_i[N-1:0];
        end
    end
    // ----------------------------------------
    // Mode, control and spurious registers
    // ----------------------------------------
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prio_ff <= {N{`FIP_RST_PRIO}};
            sens_ff <= {N{`FIP_RST_SENS}};
            spu_ff <= `FIP_RST_WORD;
            protect_mode_bit_ff <= 1'b0;
            global_mask_bit_ff <= 1'b0;
        end
        else if (ce_i && wr_i)
        begin
            if (in_smr && idx < N)
            begin
                prio_ff[3*idx +: 3] <= wdata_i[`FIP_SMR_PRIO_LSB +: 3];
                sens_ff[2*idx +: 2] <= wdata_i[`FIP_SMR_SENS_LSB +: 2];
            end
            if (addr_i == `FIP_OFS_SPU)
                spu_ff <= wdata_i;
            if (addr_i == `FIP_OFS_DCR)
            begin
                protect_mode_bit_ff <= wdata_i[`FIP_DCR_PROT];
                global_mask_bit_ff <= wdata_i[`FIP_DCR_GLOBAL_MASK_BIT];
            end
        end
    end
    // ----------------------------------------
    // Context: stack, current source, held pick
    // ----------------------------------------
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lvl_stk_ff <= {DEPTH{`FIP_RST_PRIO}};
            src_stk_ff <= {DEPTH{`FIP_RST_SRC}};
            depth_ff <= `FIP_RST_DEPTH;
            cur_src_ff <= `FIP_RST_SRC;
            held_vld_ff <= 1'b0;
            held_src_ff <= `FIP_RST_SRC;
            held_lvl_ff <= `FIP_RST_PRIO;
        end
        else if (ce_i)
        begin
            if (ivr_rd && protect_mode_bit_ff)
            begin
                held_vld_ff <= hit;
                held_src_ff <= best_src;
                held_lvl_ff <= best_prio;
            end
            else if (ack_prot)
                held_vld_ff <= 1'b0;
            if (do_push)
            begin
                lvl_stk_ff[3*depth_ff[2:0] +: 3] <= ack_lvl;
                src_stk_ff[5*depth_ff[2:0] +: 5] <= ack_src;
                depth_ff <= depth_ff + 4'h1;
                cur_src_ff <= ack_src;
            end
            else if (do_pop)
            begin
                depth_ff <= depth_ff - 4'h1;
                if (depth_ff == 4'h1)
                    cur_src_ff <= `FIP_RST_SRC;
                else
                    cur_src_ff <= src_stk_ff[5*below +: 5];
            end
        end
    end
    // ----------------------------------------
    // Request lines, registered
    // ----------------------------------------
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            normal_request_n_o <= 1'b1;
            fast_request_n_o <= 1'b1;
            wake_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // Wakeup bypasses the mask so idle still ends
            normal_request_n_o <= ~(hit & ~global_mask_bit_ff);
            fast_request_n_o <= ~(fast_raw & ~global_mask_bit_ff);
            wake_o <= hit | fast_raw;
        end
    end
    // ----------------------------------------
    // Read path through the vector memory
    // ----------------------------------------
    reg [`FIP_DW-1:0] byp;
    reg [4:0] raddr;
    reg byp_sel;
    always @*
    begin
        byp = `FIP_RST_WORD;
        raddr = idx;
        byp_sel = !in_svr;
        if (fvr_rd)
        begin
            raddr = `FIP_RST_SRC;
            byp_sel = 1'b0;
        end
        else if (ivr_rd && hit)
        begin
            raddr = best_src;
            byp_sel = 1'b0;
        end
        else if (in_smr && idx < N)
        begin
            byp[`FIP_SMR_PRIO_LSB +: 3] = prio_ff[3*idx +: 3];
            byp[`FIP_SMR_SENS_LSB +: 2] = sens_ff[2*idx +: 2];
        end
        else
        begin
            case (addr_i)
                `FIP_OFS_IVR: byp = spu_ff;
                `FIP_OFS_ISR: byp[4:0] = cur_src_ff;
                `FIP_OFS_IPR: byp[N-1:0] = ipr;
                `FIP_OFS_IMR: byp[N-1:0] = imr_ff;
                `FIP_OFS_CISR:
                begin
                    byp[`FIP_CISR_NORM] = ~normal_request_n_o;
                    byp[`FIP_CISR_FAST] = ~fast_request_n_o;
                end
                `FIP_OFS_SPU: byp = spu_ff;
                `FIP_OFS_DCR:
                begin
                    byp[`FIP_DCR_PROT] = protect_mode_bit_ff;
                    byp[`FIP_DCR_GLOBAL_MASK_BIT] = global_mask_bit_ff;
                end
                `FIP_OFS_FFSR: byp[N-1:0] = ffsr_ff;
                default: byp = `FIP_RST_WORD;
            endcase
        end
    end
    fip_vec_mem #(
        .AW(5),
        .DW(`FIP_DW)
    ) u_mem (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .we_i(wr_i && in_svr),
        .waddr_i(idx),
        .wdata_i(wdata_i),
        .re_i(rd_i),
        .raddr_i(raddr),
        .byp_sel_i(byp_sel),
        .byp_i(byp),
        .rdata_o(rdata_o)
    );
endmodule // fip_top
`default_nettype wire

// >>> rtl/fip_vec_mem.v
`timescale 1ns/1ps
`default_nettype none
module fip_vec_mem #(
    parameter AW = 5,
    parameter DW = 32
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire ce_i,
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [DW-1:0] wdata_i,
    input wire re_i,
    input wire [AW-1:0] raddr_i,
    input wire byp_sel_i,
    input wire [DW-1:0] byp_i,
    output reg [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ----------------------------------------
    // Storage, no reset to keep it RAM-like
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (ce_i && we_i)
            mem[waddr_i] <= wdata_i;
    end

    // ----------------------------------------
    // Read register, valid one cycle only
    // ----------------------------------------
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= {DW{1'b0}};
        else if (ce_i)
        begin
            if (!re_i)
                rdata_o <= {DW{1'b0}};
            else if (byp_sel_i)
                rdata_o <= byp_i;
            else
                rdata_o <= mem[raddr_i];
        end
    end
endmodule // fip_vec_mem
`default_nettype wire

// >>> verif/fip_core_mdl.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor core seen from its request inputs
// ----------------------------------------
module fip_core_mdl (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic fast_request_n_i,
    input wire logic normal_request_n_i,
    input wire logic fmask_i,
    input wire logic imask_i,
    output logic fiq_take_o,
    output logic irq_take_o
);
    // Registered take, as a core samples its lines once per cycle
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fiq_take_o <= 1'b0;
            irq_take_o <= 1'b0;
        end
        else
        begin
            fiq_take_o <= !fast_request_n_i && !fmask_i;
            irq_take_o <= !normal_request_n_i && !imask_i;
        end
    end
endmodule // fip_core_mdl
`default_nettype wire

// >>> verif/fip_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fip_regs.vh"
module fip_top_sva #(
    parameter N = 32,
    parameter DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [N-1:0] src_i,
    input wire logic [`FIP_AW-1:0] addr_i,
    input wire logic [`FIP_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`FIP_DW-1:0] rdata_o,
    input wire logic normal_request_n_o,
    input wire logic fast_request_n_o,
    input wire logic wake_o
);
    // ----------------------------------------
    // Shadow of the written state
    // ----------------------------------------
    logic [1:0] dcr_ff;
    logic [31:0] ffs_ff, imr_ff, svr0_ff, spu_ff;
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dcr_ff <= 2'h0;
            ffs_ff <= 32'h0;
            imr_ff <= 32'h0;
            svr0_ff <= 32'h0;
            spu_ff <= 32'h0;
        end
        else if (ce_i && wr_i)
        begin
            case (addr_i)
                `FIP_OFS_DCR: dcr_ff <= wdata_i[1:0];
                // Bit 0 cannot be forced, it is the fast source itself
                `FIP_OFS_FFER: ffs_ff <= ffs_ff | (wdata_i & 32'hFFFF_FFFE);
                `FIP_OFS_FFDR: ffs_ff <= ffs_ff & ~wdata_i;
                `FIP_OFS_IECR: imr_ff <= imr_ff | wdata_i;
                `FIP_OFS_IDCR: imr_ff <= imr_ff & ~wdata_i;
                9'h080: svr0_ff <= wdata_i;
                `FIP_OFS_SPU: spu_ff <= wdata_i;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    gmask_quiet_a: assert property (dcr_ff[1] |=>
        fast_request_n_o && normal_request_n_o)
        else $error("request active under global mask");
    ffsr_read_a: assert property (rd_i && addr_i == `FIP_OFS_FFSR
        |=> rdata_o == ffs_ff)
        else $error("force status differs from commands");
    dcr_read_a: assert property (rd_i && addr_i == `FIP_OFS_DCR
        |=> rdata_o == {30'h0, dcr_ff})
        else $error("debug control readback wrong");
    fvr_vector_a: assert property (rd_i && addr_i == `FIP_OFS_FVR
        |=> rdata_o == svr0_ff)
        else $error("fast vector is not source 0 vector");
    imr_bit0_a: assert property (rd_i && addr_i == `FIP_OFS_IMR
        |=> rdata_o[0] == imr_ff[0])
        else $error("mask bit 0 wrong");
    masked_quiet_a: assert property (imr_ff == 32'h0 |=>
        fast_request_n_o && normal_request_n_o)
        else $error("request with every source disabled");
    spu_read_a: assert property (rd_i && addr_i == `FIP_OFS_SPU
        |=> rdata_o == spu_ff)
        else $error("spurious vector readback wrong");
endmodule // fip_top_sva
bind fip_top fip_top_sva #(.N(N), .DEPTH(DEPTH)) u_sva (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .src_i(src_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .normal_request_n_o(normal_request_n_o),
    .fast_request_n_o(fast_request_n_o),
    .wake_o(wake_o)
);
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fip_regs.vh"
module tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [31:0] src_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [8:0] addr_i = 9'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    wire [31:0] rdata_o;
    wire nrq_n, frq_n, wake, fiq_take;
    int failures = 0;
    int comparisons = 0;
    localparam logic [31:0] VA = 32'h0000_1C00;
    localparam logic [31:0] VS = 32'h0000_5A00;
    localparam logic [31:0] V1 = 32'h0000_0840;
    localparam logic [31:0] M = 32'hFFFF_FFFF;
    always #5 clk_i = ~clk_i;
    fip_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
        .src_i(src_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .normal_request_n_o(nrq_n),
        .fast_request_n_o(frq_n), .wake_o(wake));
    fip_core_mdl u_core (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .fast_request_n_i(frq_n), .normal_request_n_i(nrq_n),
        .fmask_i(1'b0), .imask_i(1'b0), .fiq_take_o(fiq_take),
        .irq_take_o());
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, input logic [31:0] e,
        input logic [31:0] m);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o & m, e);
        @(posedge clk_i);
    endtask
    task automatic sq(input logic f, input logic n);
        @(negedge clk_i);
        chk({31'h0, frq_n}, {31'h0, f});
        chk({31'h0, nrq_n}, {31'h0, n});
        @(posedge clk_i);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_i);
        failures++;
        tally_and_finish;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(`FIP_OFS_DCR, 32'h0, M);
        rd(`FIP_OFS_FFSR, 32'h0, M);
        wr(9'h080, VA);
        wr(9'h084, V1);
        wr(`FIP_OFS_SPU, VS);
        wr(9'h000, 32'h60);
        wr(9'h004, 32'h43);
        wr(`FIP_OFS_IECR, 32'h1);
        rd(`FIP_OFS_IMR, 32'h1, 32'h1);
        src_i[0] <= 1'b1;
        cyc(3);
        sq(1'b0, 1'b1);
        @(negedge clk_i);
        chk({31'h0, fiq_take}, 32'h1);
        @(posedge clk_i);
        src_i[0] <= 1'b0;
        rd(`FIP_OFS_FVR, VA, M);
        sq(1'b1, 1'b1);
        wr(9'h000, 32'h40);
        src_i[0] <= 1'b1;
        cyc(3);
        rd(`FIP_OFS_FVR, VA, M);
        sq(1'b0, 1'b1);
        src_i[0] <= 1'b0;
        cyc(2);
        sq(1'b1, 1'b1);
        wr(9'h000, 32'h60);
        wr(`FIP_OFS_FFER, 32'h3);
        rd(`FIP_OFS_FFSR, 32'h2, M);
        wr(`FIP_OFS_IECR, 32'h2);
        src_i[0] <= 1'b1;
        cyc(3);
        sq(1'b0, 1'b1);
        src_i[0] <= 1'b0;
        rd(`FIP_OFS_FVR, VA, M);
        sq(1'b0, 1'b1);
        wr(`FIP_OFS_ICCR, 32'h1);
        cyc(1);
        sq(1'b1, 1'b1);
        src_i[1] <= 1'b1;
        cyc(3);
        sq(1'b0, 1'b1);
        rd(`FIP_OFS_IPR, 32'h0, 32'h1);
        rd(`FIP_OFS_IVR, VS, M);
        wr(`FIP_OFS_EOICR, 32'h0);
        src_i[1] <= 1'b0;
        cyc(3);
        sq(1'b1, 1'b1);
        wr(`FIP_OFS_FFDR, 32'h2);
        rd(`FIP_OFS_FFSR, 32'h0, M);
        src_i[1] <= 1'b1;
        cyc(3);
        sq(1'b1, 1'b0);
        wr(`FIP_OFS_DCR, 32'h1);
        rd(`FIP_OFS_IVR, V1, M);
        rd(`FIP_OFS_IVR, V1, M);
        rd(`FIP_OFS_ISR, 32'h0, 32'h1F);
        sq(1'b1, 1'b0);
        wr(`FIP_OFS_IVR, 32'h0);
        rd(`FIP_OFS_ISR, 32'h1, 32'h1F);
        sq(1'b1, 1'b1);
        wr(`FIP_OFS_EOICR, 32'h0);
        cyc(1);
        sq(1'b1, 1'b0);
        wr(`FIP_OFS_DCR, 32'h0);
        rd(`FIP_OFS_IVR, V1, M);
        rd(`FIP_OFS_ISR, 32'h1, 32'h1F);
        sq(1'b1, 1'b1);
        wr(`FIP_OFS_IVR, 32'h0);
        wr(`FIP_OFS_EOICR, 32'h0);
        cyc(1);
        sq(1'b1, 1'b0);
        wr(`FIP_OFS_DCR, 32'h2);
        cyc(1);
        sq(1'b1, 1'b1);
        @(negedge clk_i);
        chk({31'h0, wake}, 32'h1);
        @(posedge clk_i);
        wr(`FIP_OFS_DCR, 32'h0);
        cyc(1);
        sq(1'b1, 1'b0);
        src_i[1] <= 1'b0;
        cyc(3);
        sq(1'b1, 1'b1);
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
